//--- shared/lpbi_params.svh
`ifndef LPBI_PARAMS_SVH
`define LPBI_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LPBI_ADDR_PHASE_ZERO 8'h01
`define LPBI_ADDR_PHASE_ONE 8'h09
`define LPBI_ADDR_MASTER_NINTH 8'h0E
`define LPBI_ADDR_INTENSITY_FIRST 8'h10
`define LPBI_ADDR_INTENSITY_LAST 8'h13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPBI_MASTER_MSB 7
`define LPBI_MASTER_LSB 4
`define LPBI_NINTH_MSB 3
`define LPBI_NINTH_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPBI_RST_PHASE_ZERO 8'hFF
`define LPBI_RST_PHASE_ONE 8'hFF
`define LPBI_RST_MASTER_NINTH 8'h0F
`define LPBI_RST_INTENSITY 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPBI_CLK_HZ 100000000
`define LPBI_OSC_HZ 32000
`define LPBI_STEP_CYCLES (`LPBI_CLK_HZ / `LPBI_OSC_HZ)
`define LPBI_CYCLES_PER_SLOT 16
`define LPBI_SLOTS_PER_PERIOD 15
`define LPBI_STATIC_NIBBLE 4'hF

`endif

//--- shared/lpbi_pkg.sv
package lpbi_pkg;

  // How the drive levels are produced in the current period
  typedef enum logic [1:0] {
    LPBI_MODE_STATIC,
    LPBI_MODE_INDIVIDUAL,
    LPBI_MODE_GLOBAL
  } lpbi_mode_t;

  typedef logic [3:0] lpbi_nibble_t;

endpackage

//--- hdl/lpbi_timebase.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpbi_params.svh"

module lpbi_timebase #(
  parameter int STEP_CYCLES = `LPBI_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic [3:0] cycleIdx,
  output logic [3:0] slotIdx,
  output logic periodStart
);

  // A zero divisor would tick only once every 2^32 cycles
  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("STEP_CYCLES must be at least 1");
  end

  // ----------------------------------------
  // Step divider
  // ----------------------------------------
  logic [31:0] divCount;
  wire stepTick = (divCount == 32'(STEP_CYCLES - 1));
  wire lastCycle = (cycleIdx == 4'(`LPBI_CYCLES_PER_SLOT - 1));
  wire lastSlot = (slotIdx == 4'(`LPBI_SLOTS_PER_PERIOD - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCount <= 32'h0000_0000;
    end else begin
      divCount <= stepTick ? 32'h0000_0000 : divCount + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // 15 slots of 16 steps: 240-step period
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycleIdx <= 4'h0;
      slotIdx <= 4'h0;
    end else if (stepTick) begin
      cycleIdx <= lastCycle ? 4'h0 : cycleIdx + 4'h1;
      if (lastCycle) begin
        slotIdx <= lastSlot ? 4'h0 : slotIdx + 4'h1;
      end
    end
  end

  // Pulse on the step that wraps the period
  assign periodStart = stepTick && lastCycle && lastSlot;

endmodule
`default_nettype wire

//--- hdl/lpbi_led_pwm.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpbi_params.svh"

module lpbi_led_pwm #(
  parameter int STEP_CYCLES = `LPBI_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic blinkEnable,
  input wire logic blinkFlip,
  input wire logic globalSelect,
  input wire logic ninthLevelPhaseZero,
  input wire logic ninthLevelPhaseOne,
  output logic [7:0] mainPortOut,
  output logic [7:0] mainPortOe,
  output logic ninthOutputOut,
  output logic ninthOutputOe
);

  // ----------------------------------------
  // Host-visible registers
  // ----------------------------------------
  logic [7:0] outputLevelsPhaseZero;
  logic [7:0] outputLevelsPhaseOne;
  logic [7:0] masterAndNinthIntensity;
  logic [7:0] intensityPair [0:3];

  wire selPhaseZero = (regAddr == `LPBI_ADDR_PHASE_ZERO);
  wire selPhaseOne = (regAddr == `LPBI_ADDR_PHASE_ONE);
  wire selMaster = (regAddr == `LPBI_ADDR_MASTER_NINTH);
  wire selIntensity = (regAddr >= `LPBI_ADDR_INTENSITY_FIRST) &&
                      (regAddr <= `LPBI_ADDR_INTENSITY_LAST);
  wire [1:0] intensityIdx = regAddr[1:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outputLevelsPhaseZero <= `LPBI_RST_PHASE_ZERO;
      outputLevelsPhaseOne <= `LPBI_RST_PHASE_ONE;
      masterAndNinthIntensity <= `LPBI_RST_MASTER_NINTH;
    end else if (regWrite) begin
      if (selPhaseZero) begin
        outputLevelsPhaseZero <= regWrData;
      end
      if (selPhaseOne) begin
        outputLevelsPhaseOne <= regWrData;
      end
      if (selMaster) begin
        masterAndNinthIntensity <= regWrData;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_intensity
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          intensityPair[gi] <= `LPBI_RST_INTENSITY;
        end else if (regWrite && selIntensity && intensityIdx == 2'(gi)) begin
          intensityPair[gi] <= regWrData;
        end
      end
    end
  endgenerate

  // Unmapped addresses read as zero
  wire [7:0] readMux = selPhaseZero ? outputLevelsPhaseZero :
                       selPhaseOne ? outputLevelsPhaseOne :
                       selMaster ? masterAndNinthIntensity :
                       selIntensity ? intensityPair[intensityIdx] : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= readMux;
    end
  end

  // ----------------------------------------
  // PWM timebase
  // ----------------------------------------
  logic [3:0] cycleIdx;
  logic [3:0] slotIdx;
  logic periodStart;

  lpbi_timebase #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timebase (
    .clk(clk),
    .reset_n(reset_n),
    .cycleIdx(cycleIdx),
    .slotIdx(slotIdx),
    .periodStart(periodStart)
  );

  // ----------------------------------------
  // Period-aligned shadow copies
  // ----------------------------------------
  // Updating mid-period would chop a pulse short, so all settings
  // that shape the waveform move together at the boundary.
  logic [8:0] shLevelZero;
  logic [8:0] shLevelOne;
  logic [7:0] shMaster;
  logic [31:0] shIntensity;
  logic shBlinkEnable;
  logic shBlinkFlip;
  logic shGlobal;

  wire [31:0] liveIntensity = {intensityPair[3], intensityPair[2],
                               intensityPair[1], intensityPair[0]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shLevelZero <= 9'h1FF;
      shLevelOne <= 9'h1FF;
      shMaster <= `LPBI_RST_MASTER_NINTH;
      shIntensity <= 32'hFFFF_FFFF;
      shBlinkEnable <= 1'b0;
      shBlinkFlip <= 1'b0;
      shGlobal <= 1'b0;
    end else if (periodStart) begin
      shLevelZero <= {ninthLevelPhaseZero, outputLevelsPhaseZero};
      shLevelOne <= {ninthLevelPhaseOne, outputLevelsPhaseOne};
      shMaster <= masterAndNinthIntensity;
      shIntensity <= liveIntensity;
      shBlinkEnable <= blinkEnable;
      shBlinkFlip <= blinkFlip;
      shGlobal <= globalSelect;
    end
  end

  // ----------------------------------------
  // Mode and gating
  // ----------------------------------------
  wire [3:0] masterNibble = shMaster[`LPBI_MASTER_MSB:`LPBI_MASTER_LSB];
  wire [3:0] ninthNibble = shMaster[`LPBI_NINTH_MSB:`LPBI_NINTH_LSB];

  lpbi_pkg::lpbi_mode_t mode;
  assign mode = (masterNibble == 4'h0) ? lpbi_pkg::LPBI_MODE_STATIC :
                shGlobal ? lpbi_pkg::LPBI_MODE_GLOBAL :
                lpbi_pkg::LPBI_MODE_INDIVIDUAL;

  // Master nibble opens the first M slots of the period
  wire slotOpen = (slotIdx < masterNibble);

  // Blink phase level selection, shared by all nine outputs
  wire usePhaseOne = shBlinkEnable && shBlinkFlip;
  wire [8:0] phaseLevel = usePhaseOne ? shLevelOne : shLevelZero;

  // ----------------------------------------
  // Per-output waveform
  // ----------------------------------------
  wire [8:0] nextLevel;
  logic [8:0] driveLevel;

  generate
    for (gi = 0; gi < 9; gi++) begin : g_out
      wire [3:0] ownNibble;
      if (gi < 8) begin : g_main
        assign ownNibble = shIntensity[gi*4 +: 4];
      end else begin : g_ninth
        assign ownNibble = ninthNibble;
      end
      // One nibble for every output under global control
      wire [3:0] effNibble = (mode == lpbi_pkg::LPBI_MODE_GLOBAL) ?
                             ninthNibble : ownNibble;
      // On-time is the first nibble+1 steps of an open slot
      wire onTime = slotOpen && (cycleIdx <= effNibble);
      wire isStatic = (mode == lpbi_pkg::LPBI_MODE_STATIC) ||
                      (effNibble == `LPBI_STATIC_NIBBLE);
      assign nextLevel[gi] = (isStatic || onTime) ? phaseLevel[gi] : ~phaseLevel[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      driveLevel <= 9'h1FF;
    end else begin
      driveLevel <= nextLevel;
    end
  end

  // ----------------------------------------
  // Open-drain pins
  // ----------------------------------------
  assign mainPortOut = 8'h00;
  assign mainPortOe = ~driveLevel[7:0];
  assign ninthOutputOut = 1'b0;
  assign ninthOutputOe = ~driveLevel[8];

endmodule
`default_nettype wire

//--- dv/lpbi_led_pwm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lpbi_led_pwm_properties #(
  parameter int STEP_CYCLES = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic blinkEnable,
  input wire logic blinkFlip,
  input wire logic globalSelect,
  input wire logic ninthLevelPhaseZero,
  input wire logic ninthLevelPhaseOne,
  input wire logic [7:0] mainPortOut,
  input wire logic [7:0] mainPortOe,
  input wire logic ninthOutputOut,
  input wire logic ninthOutputOe
);
  localparam int PER = 240 * STEP_CYCLES;
  wire logic [4:0] cfg = {blinkEnable, blinkFlip, globalSelect, ninthLevelPhaseZero,
    ninthLevelPhaseOne};
  logic [4:0] cfgQ;
  int quiet;
  // One period to land a change, one more before the pattern may repeat
  wire logic settled = quiet > 2 * PER + 2;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgQ <= '0;
      quiet <= 0;
    end else begin
      cfgQ <= cfg;
      quiet <= (regWrite || cfg != cfgQ) ? 0 : quiet + (settled ? 0 : 1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_main_data_low: assert property (mainPortOut == 8'h00)
    else $error("main data not low");
  a_ninth_data_low: assert property (ninthOutputOut == 1'b0)
    else $error("ninth data not low");
  a_release_idle: assert property ($rose(reset_n) |-> mainPortOe == 8'h00 && !ninthOutputOe)
    else $error("pins driven after reset");
  a_phase0_readback: assert property (regWrite && regAddr == 8'h01 ##1 regRead && regAddr == 8'h01
    |=> regRdData == $past(regWrData, 2)) else $error("phase zero readback");
  a_phase1_readback: assert property (regWrite && regAddr == 8'h09 ##1 regRead && regAddr == 8'h09
    |=> regRdData == $past(regWrData, 2)) else $error("phase one readback");
  a_shared_readback: assert property (regWrite && regAddr == 8'h0E ##1 regRead && regAddr == 8'h0E
    |=> regRdData == $past(regWrData, 2)) else $error("intensity readback");
  a_read_holds: assert property (!regRead |=> $stable(regRdData))
    else $error("read data moved");
  a_main_periodic: assert property (settled |-> mainPortOe == $past(mainPortOe, PER))
    else $error("main pattern not periodic");
  a_ninth_periodic: assert property (settled |-> ninthOutputOe == $past(ninthOutputOe, PER))
    else $error("ninth pattern not periodic");
endmodule
`default_nettype wire

//--- dv/lpbi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpbi_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWrData
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWrData = 8'h00;
  end
  // Write then read back; released lines show inverted values, not stale ones
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    @(negedge clk);
    q = regRdData;
  endtask
endmodule
`default_nettype wire

//--- dv/led_pwm_blink_intensity_bench.sv
`timescale 1ns/1ps
`default_nettype none
module led_pwm_blink_intensity_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, mainPortOut, mainPortOe, rd;
  logic regWrite, regRead, blinkEnable, blinkFlip, globalSelect, ninthOutputOut, ninthOutputOe;
  logic ninthLevelPhaseZero, ninthLevelPhaseOne;
  logic [7:0] p0 = 8'hFF, p1 = 8'hFF, mn = 8'h0F;
  logic [3:0] own [8];
  int err_total = 0, cmp_count = 0, seed = 57;
  always #5 clk = ~clk;
  lpbi_led_pwm #(.STEP_CYCLES(1)) uut (.clk, .reset_n, .regAddr, .regWrite, .regRead,
    .regWrData, .regRdData, .blinkEnable, .blinkFlip, .globalSelect, .ninthLevelPhaseZero,
    .ninthLevelPhaseOne, .mainPortOut, .mainPortOe, .ninthOutputOut, .ninthOutputOe);
  lpbi_host_model host (.clk, .regRdData, .regAddr, .regWrite, .regRead, .regWrData);
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic setreg(input logic [7:0] a, input logic [7:0] d);
    host.wrrd(a, d, rd);
    chk(rd, (a inside {8'h01, 8'h09, 8'h0E, [8'h10:8'h13]}) ? d : 8'h00);
    if (a == 8'h01) p0 = d;
    if (a == 8'h09) p1 = d;
    if (a == 8'h0E) mn = d;
    if (a[7:2] == 6'h04) {own[2 * a[1:0] + 1], own[2 * a[1:0]]} = d;
  endtask
  // Low steps per period; index 8 is the ninth output
  function automatic logic [8:0] expPin(input int i);
    logic sel = blinkEnable && blinkFlip;
    logic lvl = (i == 8) ? (sel ? ninthLevelPhaseOne : ninthLevelPhaseZero)
      : (sel ? p1[i] : p0[i]);
    logic [3:0] n = (i == 8 || globalSelect) ? mn[3:0] : own[i];
    int on = (mn[7:4] == 4'h0 || n == 4'hF) ? 240 : mn[7:4] * (n + 1);
    return 9'(lvl ? 240 - on : on);
  endfunction
  task automatic measure();
    logic [8:0] lowCnt [9];
    repeat (484) @(negedge clk);
    lowCnt = '{default: 9'h000};
    repeat (240) begin
      @(negedge clk);
      for (int i = 0; i < 8; i++)
        lowCnt[i] += 9'(mainPortOe[i]);
      lowCnt[8] += 9'(ninthOutputOe);
    end
    for (int i = 0; i < 9; i++)
      chk(lowCnt[i], expPin(i));
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {blinkEnable, blinkFlip, globalSelect, ninthLevelPhaseZero, ninthLevelPhaseOne} = 5'h00;
    foreach (own[i]) own[i] = 4'hF;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    setreg(8'h05, 8'hA5);
    // Every blink and global combination, static master and full nibble first
    for (int k = 0; k < 8; k++) begin
      {blinkEnable, blinkFlip, globalSelect} = 3'(k);
      {ninthLevelPhaseZero, ninthLevelPhaseOne} = 2'($random(seed));
      setreg(8'h01, 8'($random(seed)));
      setreg(8'h09, 8'($random(seed)));
      for (int j = 0; j < 4; j++)
        setreg(8'h10 + 8'(j), 8'($random(seed)));
      setreg(8'h0E, k == 0 ? 8'h07 : k == 1 ? 8'hFF : 8'($random(seed)));
      measure();
    end
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
bind lpbi_led_pwm lpbi_led_pwm_properties #(.STEP_CYCLES(STEP_CYCLES)) props (.clk, .reset_n,
  .regAddr, .regWrite, .regRead, .regWrData, .regRdData, .blinkEnable, .blinkFlip, .globalSelect,
  .ninthLevelPhaseZero, .ninthLevelPhaseOne, .mainPortOut, .mainPortOe, .ninthOutputOut,
  .ninthOutputOe);
`default_nettype wire
